// ==== rtl/scr_pkg.sv ====
// package: offsets, field positions and timing constants of the system configuration register
package scr_pkg;
	// ==========================================================
	// register map
	localparam logic [15:0] SCR_SFR_ADDR = 16'hff12; // long sfr address
	localparam logic [7:0] SCR_SFR_SHORT = 8'h89; // short (bit) address
	localparam int SCR_ADDR_W = 16;
	localparam logic [15:0] SCR_RESET_BASE = 16'h0000;
	localparam logic [15:0] SCR_STRAP_MASK = 16'h0680; // bits loaded from straps
	// ==========================================================
	// field positions
	localparam int SCR_B_SHARE = 0;
	localparam int SCR_B_VISIBLE = 1;
	localparam int SCR_B_ONCHIP_PERIPH_ENABLE = 2;
	localparam int SCR_B_BDRST = 3;
	localparam int SCR_B_OSC_MONITOR_DISABLE = 4;
	localparam int SCR_B_POWERDOWN_CONFIG = 5;
	localparam int SCR_B_SELECT_LATCH_CONFIG = 6;
	localparam int SCR_B_WRITE_STROBE_CONFIG = 7;
	localparam int SCR_B_CLOCK_OUTPUT_ENABLE = 8;
	localparam int SCR_B_BYTE_HIGH_DISABLE = 9;
	localparam int SCR_B_INTERNAL_MEMORY_ENABLE = 10;
	// boot port pins that feed the strapped bits
	localparam int SCR_P_BYTE_HIGH_DISABLE = 7;
	localparam int SCR_P_WRITE_STROBE_CONFIG = 6;
	// ==========================================================
	// timing at 200 MHz
	localparam int SCR_CLK_PS = 5000;
	localparam int SCR_TCL_PS = SCR_CLK_PS; // one half clock period = one clk_sys cycle
	localparam int SCR_RST_DRIVE_TCL = 1024;
	localparam int SCR_RST_DRIVE_CYC = (SCR_RST_DRIVE_TCL * SCR_TCL_PS + SCR_CLK_PS - 1) / SCR_CLK_PS;
	// idle limit is in microseconds, so the cycle count is reckoned in picoseconds
	localparam int SCR_OSC_IDLE_US = 1;
	localparam int SCR_OSC_IDLE_CYC = (SCR_OSC_IDLE_US * 1000000 + SCR_CLK_PS - 1) / SCR_CLK_PS;
	localparam int SCR_CS_DELAY_TCL = 1;
	localparam int SCR_CNT_W = 11;
	// ==========================================================
	// power-down state machine
	typedef enum logic [2:0] {
		SCR_PD_RUN = 3'b001,
		SCR_PD_DOWN = 3'b010,
		SCR_PD_WAKE = 3'b100
	} scr_pd_t;
endpackage : scr_pkg

// ==== rtl/scr_system_config.sv ====
// system configuration register with its controlled behaviour, avalon-mm slave
// ==========================================================
// Contract
// - the register is a 16-bit bit-addressable sfr at ff12h, short address 89h.
// - reset value is 0xx0h with the middle digits taken from boot port and external access pin levels.
// - bits 10, 9 and 7 are loaded from the boot port and external access pin at reset.
// - after the end-of-init instruction all writes are ignored until the next reset.
// - bit 2 at 0 blocks on-chip peripheral accesses, at 1 allows them.
// - bit 3 at 0 keeps the reset pin input only; soft and watchdog resets do not drive it.
// - bit 3 at 1 drives the reset pin low for 1024 half clock periods in a soft or watchdog reset sequence.
// - bit 4 at 0 with pll bypassed switches to pll base clock after 1 us without crystal activity.
// - bit 4 at 1 disables the monitor; when bypassed it clocks from the crystal and powers the pll off.
// - bit 5 at 0 enters power down only while nmi is low; only external reset exits.
// - bit 5 at 1 enters only if enabled fast irq pins are inactive; any enabled pin exits.
// - bit 6 at 0 latches chip selects, updating one half clock after the strobe edge.
// - bit 6 at 1 drives chip selects unlatched on the strobe edge itself.
module scr_system_config #(
	parameter int CS_W = 5,
	parameter int IRQ_W = 8,
	parameter int RST_CYC = scr_pkg::SCR_RST_DRIVE_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [scr_pkg::SCR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [15:0] avs_writedata,
	input wire logic [1:0] avs_byteenable,
	output logic [15:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	// pins and core events
	input wire logic [15:0] boot_config_port,
	input wire logic external_access_pin_n,
	input wire logic end_init_instruction,
	input wire logic powerdown_instruction,
	input wire logic sw_reset_req,
	input wire logic wdt_reset_req,
	input wire logic nmi_pin_n,
	input wire logic [IRQ_W-1:0] fast_ext_irq_pins,
	input wire logic [IRQ_W-1:0] fast_ext_irq_enable,
	input wire logic crystal_input,
	input wire logic pll_bypass,
	input wire logic ale_strobe,
	input wire logic [CS_W-1:0] cs_decode,
	input wire logic periph_req,
	output logic periph_grant,
	output logic reset_input_pin_o,
	output logic reset_input_pin_oe_n,
	output logic internal_reset_req,
	output logic clk_sel_pll,
	output logic pll_power_on,
	output logic powerdown_active,
	output logic [CS_W-1:0] chip_select_lines,
	output logic [15:0] system_config_register,
	output logic init_locked
);
	import scr_pkg::*;

	// ==========================================================
	// pin synchronisers: first stage feeds only the second
	logic [15:0] port_s1_ff, port_s2_ff;
	logic ea_s1_ff, ea_s2_ff, nmi_s1_ff, nmi_s2_ff, xt_s1_ff, xt_s2_ff, ale_s1_ff, ale_s2_ff;
	logic [IRQ_W-1:0] irq_s1_ff, irq_s2_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			port_s1_ff <= '0;
			port_s2_ff <= '0;
			ea_s1_ff <= 1'b0;
			ea_s2_ff <= 1'b0;
			nmi_s1_ff <= 1'b1;
			nmi_s2_ff <= 1'b1;
			xt_s1_ff <= 1'b0;
			xt_s2_ff <= 1'b0;
			ale_s1_ff <= 1'b0;
			ale_s2_ff <= 1'b0;
			irq_s1_ff <= '0;
			irq_s2_ff <= '0;
		end else begin
			port_s1_ff <= boot_config_port;
			port_s2_ff <= port_s1_ff;
			ea_s1_ff <= external_access_pin_n;
			ea_s2_ff <= ea_s1_ff;
			nmi_s1_ff <= nmi_pin_n;
			nmi_s2_ff <= nmi_s1_ff;
			xt_s1_ff <= crystal_input;
			xt_s2_ff <= xt_s1_ff;
			ale_s1_ff <= ale_strobe;
			ale_s2_ff <= ale_s1_ff;
			irq_s1_ff <= fast_ext_irq_pins;
			irq_s2_ff <= irq_s1_ff;
		end
	end

	// ==========================================================
	// strap capture: straps are sampled once, on the first edges after release
	logic [1:0] strap_cnt_ff;
	wire strap_load = (strap_cnt_ff == 2'd2);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strap_cnt_ff <= 2'd0;
		end else if (strap_cnt_ff != 2'd3) begin
			strap_cnt_ff <= strap_cnt_ff + 2'd1;
		end
	end

	// ==========================================================
	// register access decode
	function automatic logic hit(input logic [SCR_ADDR_W-1:0] a);
		hit = (a == SCR_SFR_ADDR) || (a == {8'h00, SCR_SFR_SHORT});
	endfunction : hit

	logic [15:0] cfg_ff, nxt_cfg;
	logic lock_ff;
	logic rd_ack_ff;
	wire wr_ok = avs_write && hit(avs_address) && strap_cnt_ff == 2'd3;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lock_ff <= 1'b0;
		end else if (end_init_instruction) begin
			lock_ff <= 1'b1;
		end
	end

	// byte-lane merge; locked writes are dropped, strap-pending writes wait
	always_comb begin
		nxt_cfg = cfg_ff;
		if (strap_load) begin
			nxt_cfg[SCR_B_INTERNAL_MEMORY_ENABLE] = ~ea_s2_ff;
			nxt_cfg[SCR_B_BYTE_HIGH_DISABLE] = port_s2_ff[SCR_P_BYTE_HIGH_DISABLE];
			nxt_cfg[SCR_B_WRITE_STROBE_CONFIG] = port_s2_ff[SCR_P_WRITE_STROBE_CONFIG];
		end else if (wr_ok && !lock_ff) begin
			if (avs_byteenable[0]) nxt_cfg[7:0] = avs_writedata[7:0];
			if (avs_byteenable[1]) nxt_cfg[15:8] = avs_writedata[15:8];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= SCR_RESET_BASE;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// reads answer one cycle after the request; writes answer at once unless straps are pending
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_ack_ff <= 1'b0;
			avs_readdata <= '0;
			avs_response_err <= 1'b0;
		end else begin
			rd_ack_ff <= avs_read && !rd_ack_ff;
			if (avs_read && !rd_ack_ff) begin
				avs_readdata <= hit(avs_address) ? cfg_ff : 16'h0000;
				avs_response_err <= !hit(avs_address);
			end
		end
	end
	assign avs_waitrequest = (avs_read && !rd_ack_ff) || (avs_write && strap_cnt_ff != 2'd3);
	assign system_config_register = cfg_ff;
	assign init_locked = lock_ff;

	// ==========================================================
	// peripheral gate
	assign periph_grant = periph_req && cfg_ff[SCR_B_ONCHIP_PERIPH_ENABLE];

	// ==========================================================
	// reset pin drive; only a soft or watchdog reset request starts a drive
	logic [SCR_CNT_W-1:0] rst_cnt_ff;
	logic drive_ff;
	wire int_rst = sw_reset_req || wdt_reset_req;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_cnt_ff <= '0;
			drive_ff <= 1'b0;
		end else if (int_rst && cfg_ff[SCR_B_BDRST]) begin
			rst_cnt_ff <= SCR_CNT_W'(RST_CYC - 1);
			drive_ff <= 1'b1;
		end else if (rst_cnt_ff != '0) begin
			rst_cnt_ff <= rst_cnt_ff - 1'b1;
		end else begin
			drive_ff <= 1'b0;
		end
	end
	assign reset_input_pin_o = 1'b0;
	assign reset_input_pin_oe_n = !(drive_ff && cfg_ff[SCR_B_BDRST]);
	assign internal_reset_req = int_rst;

	// ==========================================================
	// oscillator monitor: counts cycles since the last crystal edge
	logic [SCR_CNT_W-1:0] osc_cnt_ff;
	logic xt_d_ff, osc_fail_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			xt_d_ff <= 1'b0;
			osc_cnt_ff <= '0;
			osc_fail_ff <= 1'b0;
		end else begin
			xt_d_ff <= xt_s2_ff;
			if (cfg_ff[SCR_B_OSC_MONITOR_DISABLE] || !pll_bypass || xt_d_ff != xt_s2_ff) begin
				osc_cnt_ff <= '0;
				osc_fail_ff <= 1'b0;
			end else if (osc_cnt_ff >= SCR_CNT_W'(SCR_OSC_IDLE_CYC - 1)) begin
				osc_fail_ff <= 1'b1;
			end else begin
				osc_cnt_ff <= osc_cnt_ff + 1'b1;
			end
		end
	end
	assign clk_sel_pll = !pll_bypass || osc_fail_ff;
	assign pll_power_on = !(pll_bypass && cfg_ff[SCR_B_OSC_MONITOR_DISABLE]);

	// ==========================================================
	// power down; only rstn leaves it in nmi mode
	scr_pd_t pd_ff;
	wire irq_act = |(irq_s2_ff & fast_ext_irq_enable);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pd_ff <= SCR_PD_RUN;
		end else begin
			case (pd_ff)
				SCR_PD_RUN: begin
					if (powerdown_instruction && !cfg_ff[SCR_B_POWERDOWN_CONFIG] && !nmi_s2_ff)
						pd_ff <= SCR_PD_DOWN;
					else if (powerdown_instruction && cfg_ff[SCR_B_POWERDOWN_CONFIG] && !irq_act)
						pd_ff <= SCR_PD_DOWN;
				end
				SCR_PD_DOWN: begin
					if (cfg_ff[SCR_B_POWERDOWN_CONFIG] && irq_act) pd_ff <= SCR_PD_WAKE;
				end
				SCR_PD_WAKE: pd_ff <= SCR_PD_RUN;
				default: pd_ff <= SCR_PD_RUN;
			endcase
		end
	end
	assign powerdown_active = (pd_ff == SCR_PD_DOWN);

	// ==========================================================
	// chip selects: one clk_sys cycle stands for one tcl
	logic ale_d_ff;
	logic [CS_W-1:0] cs_ff;
	wire ale_rise = ale_s2_ff && !ale_d_ff;
	logic ale_rise_d_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ale_d_ff <= 1'b0;
			ale_rise_d_ff <= 1'b0;
			cs_ff <= '0;
		end else begin
			ale_d_ff <= ale_s2_ff;
			ale_rise_d_ff <= ale_rise;
			if (cfg_ff[SCR_B_SELECT_LATCH_CONFIG] && ale_rise) cs_ff <= cs_decode;
			else if (!cfg_ff[SCR_B_SELECT_LATCH_CONFIG] && ale_rise_d_ff) cs_ff <= cs_decode;
		end
	end
	assign chip_select_lines = cs_ff;
endmodule : scr_system_config

// ==== tb/scr_system_config_asserts.sv ====
// checker of the system configuration register ports
module scr_system_config_asserts #(
	parameter int RST_CYC = 16,
	parameter int CS_W = 5
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [scr_pkg::SCR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic [15:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic avs_response_err,
	input wire logic periph_req,
	input wire logic periph_grant,
	input wire logic reset_input_pin_o,
	input wire logic reset_input_pin_oe_n,
	input wire logic powerdown_active,
	input wire logic [15:0] system_config_register,
	input wire logic init_locked,
	input wire logic ale_strobe,
	input wire logic [CS_W-1:0] cs_decode,
	input wire logic [CS_W-1:0] chip_select_lines
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt_ff;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// length of the current reset pin drive
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn || reset_input_pin_oe_n)
			cnt_ff <= 0;
		else
			cnt_ff <= cnt_ff + 1;
	end
	a_grant_gate: assert property (periph_grant == (periph_req & system_config_register[2]))
		else $error("grant differs from enable");
	a_read_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer timing wrong");
	a_unmapped_err: assert property (avs_read && !avs_waitrequest && avs_address != 16'hff12
		&& avs_address != 16'h0089 |-> avs_response_err && avs_readdata == 16'h0000)
		else $error("unmapped read not flagged");
	a_lock_freeze: assert property (init_locked |=> $stable(system_config_register) && init_locked)
		else $error("locked register changed");
	a_pin_low: assert property (!reset_input_pin_oe_n |-> !reset_input_pin_o)
		else $error("reset pin not driven low");
	a_pin_needs_en: assert property ($fell(reset_input_pin_oe_n) |-> $past(system_config_register[3]))
		else $error("reset pin driven while disabled");
	a_drive_len: assert property ($rose(reset_input_pin_oe_n) |-> cnt_ff == RST_CYC)
		else $error("reset pin drive length wrong");
	a_pd_hold: assert property (powerdown_active && !system_config_register[5] |=> powerdown_active)
		else $error("power down left without reset");
	// strobe passes two sync stages, so its rise is seen two edges late
	a_cs_unlatched: assert property ($past(rstn, 4) && system_config_register[6]
		&& $past(ale_strobe, 2) && !$past(ale_strobe, 3) |=> chip_select_lines == $past(cs_decode))
		else $error("unlatched chip select wrong");
	a_cs_latched: assert property ($past(rstn, 4) && !system_config_register[6]
		&& $past(ale_strobe, 3) && !$past(ale_strobe, 4) |=> chip_select_lines == $past(cs_decode))
		else $error("latched chip select wrong");
endmodule : scr_system_config_asserts

// ==== tb/scr_system_config_bench.sv ====
// self-checking bench of the system configuration register
module scr_system_config_bench;
	import scr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rstn, avs_read, avs_write, external_access_pin_n, nmi_pin_n, crystal_input;
	logic pll_bypass, ale_strobe, periph_req, avs_waitrequest, avs_response_err, periph_grant;
	logic reset_input_pin_o, reset_input_pin_oe_n, internal_reset_req, clk_sel_pll, pll_power_on;
	logic powerdown_active, init_locked, lk, rerr;
	logic [15:0] avs_address, avs_writedata, boot_config_port, avs_readdata, system_config_register;
	logic [15:0] rdat;
	logic [1:0] avs_byteenable;
	logic [7:0] fast_ext_irq_pins, fast_ext_irq_enable;
	logic [4:0] cs_decode, chip_select_lines, ce, ah;
	logic [3:0] ev;
	logic [31:0] lf = 32'hd8c3;
	int m, n, failures, compares, cyc;
	wire end_init_instruction = ev[0];
	wire powerdown_instruction = ev[1];
	wire sw_reset_req = ev[2];
	wire wdt_reset_req = ev[3];
	scr_system_config #(.RST_CYC(16)) u_dut (.*);
	// ==========================================================
	// helpers
	function automatic logic [31:0] nxt_lf(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt_lf
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(logic w, logic [15:0] a, logic [15:0] d, logic [1:0] be);
		logic [15:0] k;
		k = {{8{be[1]}}, {8{be[0]}}};
		avs_write <= w;
		avs_read <= ~w;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		rerr = avs_response_err;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (w && (a == 16'hff12 || a == 16'h0089) && !lk)
			m = (m & ~k) | (d & k);
		@(posedge clk_sys);
	endtask : bus
	task automatic pulse(int i, int w);
		ev[i] <= 1'b1;
		@(posedge clk_sys);
		ev[i] <= 1'b0;
		repeat (w) @(posedge clk_sys);
	endtask : pulse
	// reset with random straps, then the strapped value
	task automatic rst();
		rstn <= 1'b0;
		boot_config_port <= lf[15:0];
		external_access_pin_n <= lf[16];
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		m = {5'h0, ~external_access_pin_n, boot_config_port[7], 1'b0, boot_config_port[6], 7'h0};
		lk = 1'b0;
		chk("strap value", m, system_config_register);
		bus(0, 16'hff12, 0, 3);
		chk("strap read", m, rdat);
	endtask : rst
	// background random bus-cycle traffic on the chip select inputs
	always @(posedge clk_sys) begin
		lf = nxt_lf(lf);
		ale_strobe <= lf[0];
		cs_decode <= lf[5:1];
		cyc++;
		if (cyc == 6000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		{rstn, avs_read, avs_write, crystal_input, pll_bypass, periph_req, ev} = 0;
		{avs_address, avs_writedata, boot_config_port, avs_byteenable, fast_ext_irq_pins} = 0;
		{external_access_pin_n, nmi_pin_n, fast_ext_irq_enable} = 10'h3ff;
		@(posedge clk_sys);
		rst();
		for (int i = 0; i < 8; i++) begin
			bus(1, i[0] ? 16'hff12 : 16'h0089, lf[31:16], lf[1:0]);
			bus(0, i[0] ? 16'h0089 : 16'hff12, 0, 3);
			chk("read back", m, rdat);
		end
		bus(1, 16'hff14, 16'hffff, 3);
		bus(0, 16'hff14, 0, 3);
		chk("unmapped", 16'h0001, {rdat[14:0], rerr});
		chk("no alias", m, system_config_register);
		$display("end register access");
		periph_req <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			bus(1, 16'hff12, 16'h0004 * i, 3);
			chk("grant", i, periph_grant);
		end
		for (int i = 0; i < 2; i++) begin
			bus(1, 16'hff12, 16'h0008 * i, 3);
			pulse(2 + i, 0);
			n = 0;
			repeat (40) begin
				@(posedge clk_sys);
				n += !reset_input_pin_oe_n;
			end
			chk("pin drive", 16 * i, n);
		end
		$display("end reset pin");
		bus(1, 16'hff12, 16'h0000, 3);
		pll_bypass <= 1'b1;
		repeat (300) begin
			@(posedge clk_sys);
			crystal_input <= ~crystal_input;
		end
		chk("osc active", 1, {clk_sel_pll, pll_power_on});
		repeat (300) @(posedge clk_sys);
		chk("osc lost", 3, {clk_sel_pll, pll_power_on});
		bus(1, 16'hff12, 16'h0010, 3);
		repeat (4) @(posedge clk_sys);
		chk("osc off", 0, {clk_sel_pll, pll_power_on});
		$display("end oscillator");
		// chip selects follow the random strobe; model keeps a short strobe history
		for (int i = 0; i < 2; i++) begin
			bus(1, 16'hff12, 16'h0040 * i, 3);
			ah = '0;
			for (int j = 0; j < 60; j++) begin
				@(posedge clk_sys);
				ah = {ah[3:0], ale_strobe};
				if (j > 5)
					chk("chip select", ce, chip_select_lines);
				else
					ce = chip_select_lines;
				if (i ? (ah[2] && !ah[3]) : (ah[3] && !ah[4]))
					ce = cs_decode;
			end
		end
		$display("end chip select");
		bus(1, 16'hff12, 16'h0020, 3);
		fast_ext_irq_enable <= 8'h01;
		fast_ext_irq_pins <= 8'hfe;
		pulse(1, 6);
		chk("pd enter", 1, powerdown_active);
		fast_ext_irq_pins <= 8'h01;
		repeat (6) @(posedge clk_sys);
		chk("pd wake", 0, powerdown_active);
		pulse(1, 6);
		chk("pd refused", 0, powerdown_active);
		bus(1, 16'hff12, 16'h0000, 3);
		pulse(1, 6);
		chk("pd nmi high", 0, powerdown_active);
		nmi_pin_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pulse(1, 6);
		nmi_pin_n <= 1'b1;
		fast_ext_irq_pins <= 8'hff;
		repeat (8) @(posedge clk_sys);
		chk("pd held", 1, powerdown_active);
		$display("end power down");
		rst();
		chk("pd reset", 0, powerdown_active);
		bus(1, 16'hff12, 16'h1234, 3);
		pulse(0, 2);
		lk = 1'b1;
		bus(1, 16'h0089, 16'hedcb, 3);
		bus(0, 16'hff12, 0, 3);
		chk("locked", m, rdat);
		chk("lock flag", 1, init_locked);
		$display("end lock");
		conclude();
	end
endmodule : scr_system_config_bench
bind scr_system_config scr_system_config_asserts #(.RST_CYC(RST_CYC), .CS_W(CS_W)) u_chk (.*);
